// *** logic/tpp_port.v ***
// Three-pin general-purpose port: two bidirectional pins and one input-only pin.
// Holds the data latches, direction bits, pullup enables and the clock-out select.
// Assumes a synchronous processor bus with one-cycle read and write strobes,
// pins already synchronous to mclk, and a four-times bus clock supplied by the
// oscillator for the clock-out function.
// The oscillator option and the interrupt enable come from configuration as levels.
// The pad drivers, pullup devices and pin multiplexers sit outside this module.
// Outside a synchronous reset on nrst, a low clk_en freezes every register, bus strobes included.
`timescale 1ns/1ps
`include "tpp_defs.vh"

module tpp_port (
   input  wire                     mclk,
   input  wire                     nrst,
   input  wire                     clk_en,
   input  wire [`TPP_ADDR_W-1:0]   bus_addr,
   input  wire                     bus_wr,
   input  wire                     bus_rd,
   input  wire [`TPP_DATA_W-1:0]   bus_wdata,
   output reg  [`TPP_DATA_W-1:0]   bus_rdata,
   input  wire [`TPP_PIN_W-1:0]    pin_in,
   output reg  [`TPP_OUT_W-1:0]    pin_out,
   output reg  [`TPP_OUT_W-1:0]    pin_oe,
   output reg  [`TPP_PIN_W-1:0]    pullup_on,
   input  wire                     osc_internal,
   input  wire                     ext_irq_enable,
   input  wire                     quad_bus_clock,
   output reg                      osc_pin_is_clock
);

   // Register state
   reg  [`TPP_OUT_W-1:0]  latch_reg;
   reg  [`TPP_OUT_W-1:0]  dir_reg;
   reg  [`TPP_PIN_W-1:0]  pue_reg;
   reg                    cko_reg;
   reg  [`TPP_DATA_W-1:0] rdata_next;
   // Combinational next values
   wire                   wr_data;
   wire                   wr_dir;
   wire                   wr_pue;
   wire                   rd_take;
   wire                   clock_out;
   wire [`TPP_OUT_W-1:0]  oe_next;
   wire [`TPP_OUT_W-1:0]  out_next;
   wire [`TPP_PIN_W-1:0]  pull_next;
   wire [`TPP_DATA_W-1:0] data_word;
   wire [`TPP_DATA_W-1:0] dir_word;
   wire [`TPP_DATA_W-1:0] pue_word;

   // Address match used by both the write decode and the read mux
   function hit;
      input [`TPP_ADDR_W-1:0] a;
      input [`TPP_ADDR_W-1:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // Per-pin read source: latch when driven, pin level when an input
   function [`TPP_OUT_W-1:0] pin_view;
      input [`TPP_OUT_W-1:0] dir;
      input [`TPP_OUT_W-1:0] lat;
      input [`TPP_OUT_W-1:0] lvl;
      begin
         pin_view = (dir & lat) | (~dir & lvl);
      end
   endfunction

   // Pin two has no driver, so its enable always counts
   function [`TPP_PIN_W-1:0] pull_mask;
      input [`TPP_PIN_W-1:0] pue;
      input [`TPP_OUT_W-1:0] dir;
      begin
         pull_mask = pue & {`TPP_ONE1, ~dir};
      end
   endfunction

   // Bit two reads zero while the pin serves as the interrupt input
   function bit_two_view;
      input irq_on;
      input lvl;
      begin
         bit_two_view = irq_on ? `TPP_ZERO1 : lvl;
      end
   endfunction

   // Strobes are qualified by clk_en so a frozen block ignores the bus
   assign wr_data = clk_en & bus_wr & hit(bus_addr, `TPP_ADDR_DATA);
   assign wr_dir  = clk_en & bus_wr & hit(bus_addr, `TPP_ADDR_DIR);
   assign wr_pue  = clk_en & bus_wr & hit(bus_addr, `TPP_ADDR_PUE);
   assign rd_take = clk_en & bus_rd;

   // Read words, each with its unimplemented bits tied to zero
   assign data_word = {`TPP_DATA_HI0, bit_two_view(ext_irq_enable, pin_in[`TPP_BIT_IN2]),
                       pin_view(dir_reg, latch_reg, pin_in[`TPP_OUT_W-1:0])};
   assign dir_word  = {`TPP_DIR_HI0, dir_reg};
   assign pue_word  = {cko_reg, `TPP_PUE_MID0, pue_reg};

   // Clock-out takes over pin one: driven, pullup off, latch ignored
   assign clock_out = cko_reg & osc_internal;
   assign oe_next   = {dir_reg[`TPP_BIT_ONE] | clock_out, dir_reg[`TPP_BIT_ZERO]};
   // The clock is a registered sample, so edges finer than mclk are lost
   assign out_next  = {clock_out ? quad_bus_clock : latch_reg[`TPP_BIT_ONE],
                       latch_reg[`TPP_BIT_ZERO]};
   assign pull_next = pull_mask(pue_reg, dir_reg) & {`TPP_ONE1, ~clock_out, `TPP_ONE1};

   // Latches are outside reset so their power-up value stays whatever it is;
   // software must load them before turning a pin into an output
   always @(posedge mclk) begin
      if (wr_data) begin
         latch_reg <= bus_wdata[`TPP_OUT_W-1:0];
      end
   end

   // Only bits one and zero exist; pin two has no direction bit
   // so upper write bits are dropped here
   always @(posedge mclk) begin
      if (!nrst) begin
         dir_reg <= `TPP_DIR_RST;
      end else if (wr_dir) begin
         dir_reg <= bus_wdata[`TPP_OUT_W-1:0];
      end
   end

   // Bits six to three of this register are not kept
   always @(posedge mclk) begin
      if (!nrst) begin
         pue_reg <= `TPP_PUE_RST;
      end else if (wr_pue) begin
         pue_reg <= bus_wdata[`TPP_PIN_W-1:0];
      end
   end

   // Clock-out select shares the pullup register address
   always @(posedge mclk) begin
      if (!nrst) begin
         cko_reg <= `TPP_CKO_RST;
      end else if (wr_pue) begin
         cko_reg <= bus_wdata[`TPP_BIT_CKO];
      end
   end

   // Unmapped addresses read as zero
   always @* begin
      rdata_next = `TPP_ZERO8;
      if (hit(bus_addr, `TPP_ADDR_DATA)) begin
         rdata_next = data_word;
      end else if (hit(bus_addr, `TPP_ADDR_DIR)) begin
         rdata_next = dir_word;
      end else if (hit(bus_addr, `TPP_ADDR_PUE)) begin
         rdata_next = pue_word;
      end
   end

   // Read data is captured only on a taken read and holds otherwise
   always @(posedge mclk) begin
      if (!nrst) begin
         bus_rdata <= `TPP_ZERO8;
      end else if (rd_take) begin
         bus_rdata <= rdata_next;
      end
   end

   // Registered pin controls add one cycle of latency after a register write
   always @(posedge mclk) begin
      if (!nrst) begin
         pin_oe <= `TPP_DIR_RST;
      end else if (clk_en) begin
         pin_oe <= oe_next;
      end
   end

   // The latch is presented even on inputs so a direction change shows it at once
   always @(posedge mclk) begin
      if (!nrst) begin
         pin_out <= `TPP_DIR_RST;
      end else if (clk_en) begin
         pin_out <= out_next;
      end
   end

   // Pullups follow direction dynamically, with no software action needed
   always @(posedge mclk) begin
      if (!nrst) begin
         pullup_on <= `TPP_PUE_RST;
      end else if (clk_en) begin
         pullup_on <= pull_next;
      end
   end

   // Tells the pad mux that pin one carries the clock, not the port
   always @(posedge mclk) begin
      if (!nrst) begin
         osc_pin_is_clock <= `TPP_CKO_RST;
      end else if (clk_en) begin
         osc_pin_is_clock <= clock_out;
      end
   end

endmodule

// *** inc/tpp_defs.vh ***
// Constants for the three-pin port with pullups.
// Included by the port logic; holds definitions only.
`ifndef TPP_DEFS_VH
`define TPP_DEFS_VH
`define TPP_ADDR_W        16
`define TPP_DATA_W        8
// Data latch address; direction and pullup registers have no printed address
`define TPP_ADDR_DATA     16'h0002
`define TPP_ADDR_DIR      16'h0006
`define TPP_ADDR_PUE      16'h000c
`define TPP_PIN_W         3
`define TPP_OUT_W         2
`define TPP_DIR_RST       2'h0
`define TPP_PUE_RST       3'h0
`define TPP_CKO_RST       1'h0
`define TPP_BIT_IN2       2
`define TPP_BIT_ONE       1
`define TPP_BIT_ZERO      0
`define TPP_ONE1          1'h1
`define TPP_ZERO1         1'h0
`define TPP_DATA_HI0      5'h00
`define TPP_DIR_HI0       6'h00
`define TPP_PUE_MID0      4'h0
`define TPP_BIT_CKO       7
`define TPP_ZERO8         8'h00
`endif

// *** test/tpp_port_chk.sv ***
// Checker for the port: bus, pin and clock-out timing.
// Sees only tpp_port ports; checks are disabled while clk_en is low.
`timescale 1ns/1ps
module tpp_port_chk(input logic mclk,nrst,clk_en,bus_wr,bus_rd,osc_internal,ext_irq_enable,
   quad_bus_clock,osc_pin_is_clock,input logic [15:0] bus_addr,input logic [7:0] bus_wdata,
   bus_rdata,input logic [2:0] pin_in,pullup_on,input logic [1:0] pin_out,pin_oe);
default clocking @(posedge mclk); endclocking
default disable iff (!nrst || !clk_en);
cko_val_a: assert property (osc_pin_is_clock |->
   pin_out[1]==$past(quad_bus_clock)) else $error("clock value");
rst_clr_a: assert property ($rose(nrst) |->
   pin_oe==0 && pullup_on==0) else $error("reset");
dir_set_a: assert property (bus_wr && bus_addr==16'h6 |-> ##2
   pin_oe[0]==$past(bus_wdata[0],2)) else $error("dir");
lat_out_a: assert property (bus_wr && bus_addr==16'h2 |-> ##2
   !pin_oe[0] || pin_out[0]==$past(bus_wdata[0],2)) else $error("latch");
pu_two_a: assert property (bus_wr && bus_addr==16'hc |-> ##2
   pullup_on[2]==$past(bus_wdata[2],2)) else $error("pullup");
pu_off_a: assert property (pin_oe!=0 |->
   (pin_oe&pullup_on[1:0])==0) else $error("pullup out");
cko_pin_a: assert property (osc_pin_is_clock |->
   pin_oe[1] && !pullup_on[1]) else $error("clock out");
irq_rd_a: assert property (bus_rd && bus_addr==16'h2 && ext_irq_enable |=>
   !bus_rdata[2]) else $error("bit two");
pin_rd_a: assert property (bus_rd && bus_addr==16'h2 && !ext_irq_enable |=>
   bus_rdata[2]==$past(pin_in[2])) else $error("pin");
endmodule

// *** test/tpp_port_tb_top.sv ***
// Random and corner tests of the port; clk_en stays high except in the one corner test that drops it.
`timescale 1ns/1ps
module tpp_port_tb_top;
logic mclk=0,nrst=0,bus_wr=0,bus_rd=0,osc_internal=0,ext_irq_enable=0,quad_bus_clock=0,clk_en=1;
logic osc_pin_is_clock; logic [15:0] bus_addr=0; logic [7:0] bus_wdata=0,bus_rdata;
logic [2:0] pin_in=0,pullup_on,pe; logic [1:0] pin_out,pin_oe,dir,lat;
int num_errors=0,n_checks=0;
always #5 mclk=~mclk;
always @(posedge mclk) quad_bus_clock<=1'($urandom);
tpp_port DUT(.mclk(mclk),.nrst(nrst),.clk_en(clk_en),.bus_addr(bus_addr),.bus_wr(bus_wr),
   .bus_rd(bus_rd),.bus_wdata(bus_wdata),.bus_rdata(bus_rdata),.pin_in(pin_in),
   .pin_out(pin_out),.pin_oe(pin_oe),.pullup_on(pullup_on),.osc_internal(osc_internal),
   .ext_irq_enable(ext_irq_enable),.quad_bus_clock(quad_bus_clock),
   .osc_pin_is_clock(osc_pin_is_clock));
task chk(input logic [7:0] g,e);
   n_checks++;
   if(g!==e) begin num_errors++; $display("BAD %0t %h/%h",$time,g,e); end
endtask
task acc(input logic w,input logic [15:0] a,input logic [7:0] d);
   @(posedge mclk); bus_addr<=a; bus_wr<=w; bus_rd<=!w; bus_wdata<=d;
   @(posedge mclk); bus_wr<=0; bus_rd<=0; @(negedge mclk);
endtask
task wrap_up;
   $display("checks %0d errors %0d",n_checks,num_errors);
   if(num_errors==0&&n_checks>0) $display("RESULT: PASS"); else $display("RESULT: FAIL");
   $finish;
endtask
initial begin #40000; num_errors++; wrap_up; end
initial begin
   void'($urandom(28)); repeat(3) @(posedge mclk); nrst<=1; @(negedge mclk);
   chk({pin_oe,pullup_on},0); acc(0,16'h6,0); chk(bus_rdata,0);
   acc(0,16'h10,0); chk(bus_rdata,0); $display("reset done");
   repeat(40) begin
      dir=2'($urandom); lat=2'($urandom); pe=3'($urandom); @(posedge mclk);
      pin_in<=3'($urandom); ext_irq_enable<=1'($urandom); osc_internal<=1'($urandom);
      acc(1,16'h2,{6'h3f,lat}); acc(1,16'h6,{6'h3f,dir}); acc(1,16'hc,{5'h0f,pe});
      acc(0,16'h2,0); // Latch on outputs, pin level on inputs
      chk(bus_rdata,{5'h0,!ext_irq_enable&pin_in[2],dir&lat|~dir&pin_in[1:0]});
      acc(0,16'hc,0); chk(bus_rdata,{5'h0,pe});
      chk({pin_out&dir,pin_oe},{lat&dir,dir});
      chk(pullup_on,{pe[2],pe[1:0]&~dir});
   end
   $display("random done");
   @(posedge mclk) osc_internal<=1; acc(1,16'hc,8'h83); acc(0,16'hc,0);
   chk({osc_pin_is_clock,pin_oe[1],pullup_on[1]},3'b110);
   @(posedge mclk) osc_internal<=0; acc(0,16'hc,0); chk(osc_pin_is_clock,0);
   @(posedge mclk) nrst<=0; @(posedge mclk) nrst<=1; acc(1,16'h6,8'h03); acc(0,16'h6,0);
   chk(pin_out,lat);
   @(posedge mclk) clk_en<=0; acc(1,16'h6,8'h00); chk(pin_oe,2'h3);
   @(posedge mclk) clk_en<=1; acc(0,16'h6,0); chk(bus_rdata,8'h03);
   $display("corner done"); wrap_up;
end
endmodule
bind tpp_port tpp_port_chk chk_i(.mclk(mclk),.nrst(nrst),.clk_en(clk_en),.bus_wr(bus_wr),
   .bus_rd(bus_rd),.osc_internal(osc_internal),.ext_irq_enable(ext_irq_enable),
   .quad_bus_clock(quad_bus_clock),.osc_pin_is_clock(osc_pin_is_clock),.bus_addr(bus_addr),
   .bus_wdata(bus_wdata),.bus_rdata(bus_rdata),.pin_in(pin_in),.pullup_on(pullup_on),
   .pin_out(pin_out),.pin_oe(pin_oe));
